/* File: tb_top.sv */
// self-checking bench for the thermal monitor flag top
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tmf_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    tmf_temp_t temp = 9'h019;
    logic run = 1'b1;
    logic on = 1'b1;
    logic cont = 1'b1;
    logic [5:0] blk = 6'h00;
    logic [5:0] clr, flag, live;
    logic pwr, samp, sd, irq_n;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    always #10 mclk = ~mclk;
    tmf_host host (.mclk(mclk), .flag_clear_wr(clr));
    tmf_top #(.DB_CYC(4), .WIN_CYC(20), .INT_CYC(100)) dut (.mclk(mclk), .rst_b(rst_b),
        .die_centre_temp(temp), .run_state(run), .temp_watch_on(on),
        .temp_watch_continuous(cont), .overtemp_event_block(blk), .flag_clear_wr(clr),
        .overtemp_event_flag(flag), .overtemp_live_state(live), .sensor_power(pwr),
        .mode_sample(samp), .shutdown_req(sd), .irq_out_n(irq_n));
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // bounded wait; sampling mode needs a whole interval, hence the wide bound
    task automatic wait_live(input logic [5:0] exp);
        n = 0;
        while (live !== exp && n < 300) begin
            tick(1);
            n++;
        end
        if (live !== exp) begin
            miscompares++;
            complete_run();
        end
    endtask
    initial begin
        tick(3);
        rst_b <= 1'b1;
        tick(1);
        check({flag, irq_n}, {6'h00, 1'b1});
        check({pwr, samp}, 2'b10);
        temp <= 9'h050;
        tick(12);
        check(live, 6'h00);
        temp <= 9'h051;
        tick(4);
        check(live, 6'h00);
        wait_live(6'h01);
        check({flag, irq_n}, {6'h01, 1'b0});
        temp <= 9'h04C;
        tick(12);
        check(live, 6'h01);
        temp <= 9'h04B;
        tick(4);
        check(live, 6'h01);
        wait_live(6'h00);
        blk <= 6'h01;
        tick(2);
        check(irq_n, 1'b1);
        host.clear_flags(6'h01);
        tick(2);
        check(flag, 6'h00);
        blk <= 6'h00;
        $display("test warning done");
        temp <= 9'h05F;
        tick(12);
        check(live, 6'h01);
        temp <= 9'h07D;
        tick(12);
        check(live, 6'h07);
        temp <= 9'h09B;
        tick(12);
        check(live, 6'h1F);
        temp <= 9'h0A6;
        wait_live(6'h3F);
        tick(3);
        check({flag, sd}, {6'h3F, 1'b1});
        temp <= 9'h097;
        tick(12);
        check(sd, 1'b1);
        temp <= 9'h096;
        wait_live(6'h1F);
        tick(3);
        check(sd, 1'b0);
        $display("test shutdown done");
        on <= 1'b0;
        temp <= 9'h019;
        tick(12);
        check({pwr, live}, {1'b0, 6'h1F});
        on <= 1'b1;
        wait_live(6'h00);
        cont <= 1'b0;
        temp <= 9'h051;
        wait_live(6'h01);
        n = 0;
        repeat (100) begin
            tick(1);
            n += pwr;
        end
        check(n[8:0], 9'h014);
        tick(20);
        temp <= 9'h019;
        tick(12);
        check({pwr, live}, {1'b0, 6'h01});
        wait_live(6'h00);
        run <= 1'b0;
        cont <= 1'b1;
        tick(3);
        check(samp, 1'b1);
        $display("test modes done");
        complete_run();
    end
endmodule
bind tmf_top tmf_chk #(.NUM_THR(NUM_THR), .WIN_CYC(WIN_CYC)) chk (.mclk(mclk), .rst_b(rst_b),
    .die_centre_temp(die_centre_temp), .run_state(run_state), .temp_watch_on(temp_watch_on),
    .temp_watch_continuous(temp_watch_continuous), .overtemp_event_flag(overtemp_event_flag),
    .overtemp_live_state(overtemp_live_state), .sensor_power(sensor_power),
    .mode_sample(mode_sample), .shutdown_req(shutdown_req), .irq_out_n(irq_out_n));
`default_nettype wire

/* File: tmf_chan.sv */
// one hysteretic, debounced threshold comparator channel
`timescale 1ns/1ns
`default_nettype none
`include "tmf_params.svh"
module tmf_chan
    import tmf_pkg::*;
#(
    parameter tmf_temp_t THR = `TMF_THR_80,
    parameter tmf_temp_t HYS = `TMF_WARN_HYS,
    parameter int DB_CYC = `TMF_DB_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    tmf_cmp_if.chan cmp
);
    logic state_ff, nxt_state;
    logic [15:0] db_ff, nxt_db;
    logic raw;

    always_comb begin
        // hysteresis: set above threshold, release at or below threshold minus hys
        if (state_ff) begin
            raw = (cmp.temp > (THR - HYS));
        end else begin
            raw = (cmp.temp > THR);
        end
        nxt_state = state_ff;
        nxt_db = 16'h0000;
        // outside a sampling window the state simply holds
        if (cmp.active && (raw != state_ff)) begin
            if (db_ff >= 16'(DB_CYC - 1)) begin
                nxt_state = raw;
            end else begin
                nxt_db = db_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_ff <= 1'b0;
            db_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            db_ff <= nxt_db;
        end
    end

    assign cmp.live = state_ff;
endmodule
`default_nettype wire

/* File: tmf_cmp_if.sv */
// comparator request and debounced answer between top and threshold channels
`timescale 1ns/1ns
`default_nettype none
interface tmf_cmp_if;
    import tmf_pkg::*;
    logic active;
    tmf_temp_t temp;
    logic live;
    modport top (output active, output temp, input live);
    modport chan (input active, input temp, output live);
endinterface
`default_nettype wire

/* File: tmf_duty.sv */
// sampling window timer for duty-cycled operation
`timescale 1ns/1ns
`default_nettype none
`include "tmf_params.svh"
module tmf_duty #(
    parameter int WIN_CYC = `TMF_WIN_CYC,
    parameter int INT_CYC = `TMF_INT_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic run,
    output logic window
);
    logic [23:0] cnt_ff, nxt_cnt;

    always_comb begin
        nxt_cnt = 24'h000000;
        if (run) begin
            if (cnt_ff >= 24'(INT_CYC - 1)) begin
                nxt_cnt = 24'h000000;
            end else begin
                nxt_cnt = cnt_ff + 24'h000001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_ff <= 24'h000000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // window opens at the start of every interval
    assign window = run && (cnt_ff < 24'(WIN_CYC));
endmodule
`default_nettype wire

/* File: tmf_host.sv */
// host model: clears latched flags with a one-cycle write-one pulse
`timescale 1ns/1ns
`default_nettype none
module tmf_host (
    input wire logic mclk,
    output logic [5:0] flag_clear_wr
);
    initial flag_clear_wr = 6'h00;
    // pulse lasts one cycle; a longer one would swallow a fresh event
    task automatic clear_flags(input logic [5:0] m);
        @(posedge mclk);
        flag_clear_wr <= m;
        @(posedge mclk);
        flag_clear_wr <= 6'h00;
    endtask
endmodule
`default_nettype wire

/* File: tmf_params.svh */
// constants of the thermal monitor flag logic
`ifndef TMF_PARAMS_SVH
`define TMF_PARAMS_SVH
`define TMF_CLK_MHZ 50
`define TMF_NUM_THR 6
`define TMF_TEMP_W 9
`define TMF_THR_80 9'h050
`define TMF_THR_95 9'h05F
`define TMF_THR_110 9'h06E
`define TMF_THR_125 9'h07D
`define TMF_THR_140 9'h08C
`define TMF_THR_155 9'h09B
`define TMF_THR_SD 9'h0A5
`define TMF_WARN_HYS 9'h005
`define TMF_SD_HYS 9'h00F
`define TMF_DB_US 10
`define TMF_DB_CYC (`TMF_DB_US * `TMF_CLK_MHZ)
`define TMF_WIN_US 450
`define TMF_WIN_CYC (`TMF_WIN_US * `TMF_CLK_MHZ)
`define TMF_INT_US 3000
`define TMF_INT_CYC (`TMF_INT_US * `TMF_CLK_MHZ)
`endif

/* File: tmf_pkg.sv */
// types of the thermal monitor flag logic
`default_nettype none
package tmf_pkg;
    typedef enum logic [1:0] {
        TMF_OFF = 2'b00,
        TMF_CONT = 2'b01,
        TMF_SAMPLE = 2'b10
    } tmf_mode_t;
    typedef logic [8:0] tmf_temp_t;
endpackage
`default_nettype wire

/* File: tmf_top.sv */
// thermal monitor flags: warning thresholds, shutdown latch and power duty control
// Summary of operation
// - only the die-centre sensor feeds warnings and shutdown.
// - six thresholds 80..155 C, each with flag, live state and block bit.
// - live state sets above threshold, clears 5 C below it.
// - above 165 C start shutdown; block restart until 15 C cooler.
// - comparator changes either way are debounced 10 us.
// - enable bit clear disables monitoring; set enables it.
// - run state with continuous bit set keeps monitor always powered.
// - continuous bit clear: powered 450 us every 3.0 ms.
// - run state supports continuous and sampling, chosen by continuous bit.
// - standby forces sampling, only while enable bit is set.
// - unblocked set flag drives active-low interrupt pin low.
`timescale 1ns/1ns
`default_nettype none
`include "tmf_params.svh"
module tmf_top
    import tmf_pkg::*;
#(
    parameter int NUM_THR = `TMF_NUM_THR,
    parameter int DB_CYC = `TMF_DB_CYC,
    parameter int WIN_CYC = `TMF_WIN_CYC,
    parameter int INT_CYC = `TMF_INT_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire tmf_temp_t die_centre_temp,
    input wire logic run_state,
    input wire logic temp_watch_on,
    input wire logic temp_watch_continuous,
    input wire logic [NUM_THR-1:0] overtemp_event_block,
    input wire logic [NUM_THR-1:0] flag_clear_wr,
    output logic [NUM_THR-1:0] overtemp_event_flag,
    output logic [NUM_THR-1:0] overtemp_live_state,
    output logic sensor_power,
    output logic mode_sample,
    output logic shutdown_req,
    output logic irq_out_n
);
    localparam tmf_temp_t THR_TAB [0:5] = '{`TMF_THR_80, `TMF_THR_95, `TMF_THR_110,
        `TMF_THR_125, `TMF_THR_140, `TMF_THR_155};

    tmf_mode_t mode;
    logic window, active;
    logic [NUM_THR-1:0] live, live_d_ff, nxt_live_d;
    logic [NUM_THR-1:0] flag_ff, nxt_flag;
    logic sd_live, sd_ff, nxt_sd, irq_n_ff, nxt_irq_n;

    always_comb begin
        if (!temp_watch_on) begin
            mode = TMF_OFF;
        end else if (run_state && temp_watch_continuous) begin
            mode = TMF_CONT;
        end else begin
            // standby ignores the continuous bit
            mode = TMF_SAMPLE;
        end
    end

    tmf_duty #(.WIN_CYC(WIN_CYC), .INT_CYC(INT_CYC)) u_duty (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(mode == TMF_SAMPLE),
        .window(window)
    );

    always_comb begin
        case (mode)
            TMF_CONT: active = 1'b1;
            TMF_SAMPLE: active = window;
            default: active = 1'b0;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NUM_THR; g++) begin : g_thr
            tmf_cmp_if cmp ();
            assign cmp.active = active;
            assign cmp.temp = die_centre_temp;
            assign live[g] = cmp.live;
            tmf_chan #(.THR(THR_TAB[g]), .HYS(`TMF_WARN_HYS), .DB_CYC(DB_CYC)) u_chan (
                .mclk(mclk),
                .rst_b(rst_b),
                .cmp(cmp.chan)
            );
        end
    endgenerate

    // shutdown comparator reuses the channel with the wider hysteresis
    tmf_cmp_if sd_cmp ();
    assign sd_cmp.active = active;
    assign sd_cmp.temp = die_centre_temp;
    assign sd_live = sd_cmp.live;
    tmf_chan #(.THR(`TMF_THR_SD), .HYS(`TMF_SD_HYS), .DB_CYC(DB_CYC)) u_sd (
        .mclk(mclk),
        .rst_b(rst_b),
        .cmp(sd_cmp.chan)
    );

    always_comb begin
        nxt_live_d = live;
        // the set beats a same-cycle clear write
        nxt_flag = (flag_ff & ~flag_clear_wr) | (live & ~live_d_ff);
        nxt_sd = sd_live;
        nxt_irq_n = ~|(nxt_flag & ~overtemp_event_block);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            live_d_ff <= '0;
            flag_ff <= '0;
            sd_ff <= 1'b0;
            irq_n_ff <= 1'b1;
        end else begin
            live_d_ff <= nxt_live_d;
            flag_ff <= nxt_flag;
            sd_ff <= nxt_sd;
            irq_n_ff <= nxt_irq_n;
        end
    end

    assign overtemp_event_flag = flag_ff;
    assign overtemp_live_state = live_d_ff;
    assign sensor_power = active;
    assign mode_sample = (mode == TMF_SAMPLE);
    // held until the die has cooled 15 C below the trip point
    assign shutdown_req = sd_ff;
    assign irq_out_n = irq_n_ff;
endmodule
`default_nettype wire

/* File: tmf_top_sva.sv */
// port assertions of the thermal monitor flag top
`timescale 1ns/1ns
`default_nettype none
`include "tmf_params.svh"
module tmf_chk
    import tmf_pkg::*;
#(
    parameter int NUM_THR = `TMF_NUM_THR,
    parameter int WIN_CYC = `TMF_WIN_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire tmf_temp_t die_centre_temp,
    input wire logic run_state,
    input wire logic temp_watch_on,
    input wire logic temp_watch_continuous,
    input wire logic [NUM_THR-1:0] overtemp_event_flag,
    input wire logic [NUM_THR-1:0] overtemp_live_state,
    input wire logic sensor_power,
    input wire logic mode_sample,
    input wire logic shutdown_req,
    input wire logic irq_out_n
);
    logic [15:0] on_ff;
    logic [15:0] nxt_on;
    always_comb nxt_on = (sensor_power && mode_sample) ? on_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge mclk) on_ff <= rst_b ? nxt_on : 16'h0000;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_idle3; !sensor_power[*3]; endsequence
    sequence s_cont; run_state && temp_watch_on && temp_watch_continuous; endsequence
    sequence s_stby; !run_state && temp_watch_on; endsequence
    a_irq_quiet: assert property (overtemp_event_flag == '0 |-> irq_out_n)
        else $error("irq low with no flag");
    a_flag_latch: assert property ((overtemp_live_state & ~$past(overtemp_live_state)
        & ~overtemp_event_flag) == '0) else $error("flag missed a rise");
    a_hold_idle: assert property (s_idle3 |=> $stable(overtemp_live_state))
        else $error("live state moved while unpowered");
    a_watch_off: assert property (!temp_watch_on ##1 !temp_watch_on |-> !sensor_power)
        else $error("powered while disabled");
    a_cont_on: assert property (s_cont ##1 s_cont |-> sensor_power && !mode_sample)
        else $error("continuous mode not powered");
    a_stby_sample: assert property (s_stby ##1 s_stby |-> mode_sample)
        else $error("standby not sampling");
    a_window_max: assert property (on_ff <= WIN_CYC) else $error("window too long");
    a_warn_rise: assert property ($rose(overtemp_live_state[0])
        |-> $past(die_centre_temp, 2) > `TMF_THR_80) else $error("warning set too cool");
    a_sd_rise: assert property ($rose(shutdown_req)
        |-> $past(die_centre_temp, 2) > `TMF_THR_SD) else $error("shutdown too cool");
    a_sd_fall: assert property ($fell(shutdown_req)
        |-> $past(die_centre_temp, 2) <= `TMF_THR_SD - `TMF_SD_HYS) else $error("early restart");
endmodule
`default_nettype wire
